// >>> drive_ctl.sv
// Analog frequency source selection and trip reset terminal control
`timescale 1ns/1ps
`include "drive_ctl_regs.svh"
// How it works
// R01: Select input on picks the current analog input as setpoint source.
// R02: Select input off picks the voltage analog input as setpoint source.
// R03: Terminal selection only acts when frequency source selects analog terminals.
// R04: No terminal assigned to select function means select reads as off.
// R05: Analog select value 04 forces voltage, 05 forces current, 02, 03 and 09 pair pot.
// R06: Exactly one analog source is active, never two together; the code gives SRC_NONE after reset and when the source is not analog.
// R07: Reset runs on input on then off, and cancels any trip.
// R08: Partner holds reset input on for at least 12 ms.
// R09: Alarm output clears within 30 ms of reset onset.
// R10: While reset is on, drive is off, trip cleared, power-up reset held.
// R11: Reset terminal works only normally open; inverted setting is ignored.
// R12: Power-on runs the same reset sequence as a reset pulse.
// R13: Reset during run removes drive at once, motor coasts.
// R14: Without off delay, drive and logic outputs drop together at once.
// R15: Outputs with off delay stay on about one second after reset onset.
// R16: Drive resumes right after reset if run command still active.
// R17: Local stop key honoured only a few seconds after power-up with remote.
// R18: Terminals are synchronised and debounced before use.
module drive_ctl #(
  parameter int N        = `NUM_TERMINALS,
  parameter int NOUT     = 3,
  parameter int DEB_CYC  = `DEBOUNCE_CYC,
  parameter int HOLD_CYC = `OFF_DELAY_HOLD_CYC,
  parameter int POT_CYC  = `POT_WINDOW_CYC,
  parameter int RMIN_CYC = `RESET_MIN_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // Terminals and their configuration
  input  wire logic [N-1:0] terminal_i,
  input  wire logic [7:0]  input_terminal_function_params_i [N],
  input  wire logic [N-1:0] terminal_invert_i,
  // Frequency configuration
  input  wire logic [7:0]  frequency_source_param_i,
  input  wire logic [7:0]  analog_select_param_i,
  // Drive state
  input  wire logic        run_cmd_i,
  input  wire logic        trip_event_i,
  input  wire logic        remote_attached_i,
  input  wire logic        stop_key_i,
  input  wire logic [NOUT-1:0] logic_out_req_i,
  input  wire logic [NOUT-1:0] off_delay_nonzero_i,
  // Outputs
  output logic [1:0]       active_source_o,
  output logic             analog_freq_en_o,
  output logic             drive_en_o,
  output logic             alarm_o,
  output logic             trip_o,
  output logic             powerup_reset_o,
  output logic [NOUT-1:0]  logic_out_o,
  output logic             stop_key_accept_o
);
  terminal_if #(.N(N)) tif ();

  terminal_filter #(.N(N), .DEB_CYC(DEB_CYC)) u_filter (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .raw_i   (terminal_i),
    .out     (tif)
  );

  // ************************************************************
  // Terminal function decode
  // ************************************************************
  // Collects the level of every terminal assigned a function code
  function automatic logic func_level(input logic [N-1:0] lvl,
                                      input logic [N-1:0] inv,
                                      input logic [7:0]   code,
                                      input logic         allow_inv);
    logic r;
    r = 1'b0;
    for (int i = 0; i < N; i++)
      if (input_terminal_function_params_i[i] == code)
        r = r | (allow_inv ? (lvl[i] ^ inv[i]) : lvl[i]);
    return r;
  endfunction

  logic sel_level;
  logic rst_level;
  // Unassigned select gives zero; reset ignores inversion setting.
  // A process, so a change of a function code alone re-evaluates too
  always_comb
  begin
    sel_level = func_level(tif.level, terminal_invert_i, `FUNC_ANALOG_SELECT, 1'b1); // [R04]
    rst_level = func_level(tif.level, terminal_invert_i, `FUNC_TRIP_RESET, 1'b0); // [R11]
  end

  // ************************************************************
  // Analog source selection
  // ************************************************************
  drive_ctl_pkg::src_t src_next;
  // One source at a time by construction of the enum
  always_comb
  begin
    unique case (analog_select_param_i)
      `ASEL_FORCE_VOLTAGE:    src_next = drive_ctl_pkg::SRC_VOLTAGE; // [R05]
      `ASEL_FORCE_CURRENT:    src_next = drive_ctl_pkg::SRC_CURRENT; // [R05]
      `ASEL_POT_OR_VOLTAGE:   src_next = sel_level ? drive_ctl_pkg::SRC_POT
                                                   : drive_ctl_pkg::SRC_VOLTAGE;
      `ASEL_POT_OR_CURRENT,
      `ASEL_POT_OR_CURRENT_B: src_next = sel_level ? drive_ctl_pkg::SRC_POT
                                                   : drive_ctl_pkg::SRC_CURRENT;
      default:                src_next = sel_level ? drive_ctl_pkg::SRC_CURRENT  // [R01]
                                                   : drive_ctl_pkg::SRC_VOLTAGE; // [R02]
    endcase
    if (frequency_source_param_i != `FREQ_SRC_ANALOG)
      src_next = drive_ctl_pkg::SRC_NONE; // [R03]
  end

  drive_ctl_pkg::src_t src_reg;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      src_reg <= drive_ctl_pkg::SRC_NONE;
    else if (ce_i)
      src_reg <= src_next; // [R06]
  end
  assign active_source_o  = src_reg;

  // Enable kept in its own flop so the output comes from a register
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      analog_freq_en_o <= 1'b0;
    else if (ce_i)
      analog_freq_en_o <= (src_next != drive_ctl_pkg::SRC_NONE); // [R03]
  end

  // ************************************************************
  // Reset sequencing
  // ************************************************************
  drive_ctl_pkg::rst_state_t rst_state;
  logic [31:0] hold_cnt;
  logic        pwr_pend;
  logic        trip_reg;
  logic        pwrrst_reg;

  // Power-on acts as a reset pulse; held state keeps drive off
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rst_state <= drive_ctl_pkg::RST_RELEASE; // [R12]
      hold_cnt  <= '0;
    end
    else if (ce_i)
    begin
      unique case (rst_state)
        drive_ctl_pkg::RST_IDLE:
          if (rst_level)
            rst_state <= drive_ctl_pkg::RST_HELD;
        drive_ctl_pkg::RST_HELD:
          if (!rst_level)
            rst_state <= drive_ctl_pkg::RST_RELEASE; // [R07]
        drive_ctl_pkg::RST_RELEASE:
          rst_state <= rst_level ? drive_ctl_pkg::RST_HELD : drive_ctl_pkg::RST_IDLE;
      endcase
      hold_cnt <= rst_level ? ((hold_cnt < 32'(HOLD_CYC)) ? hold_cnt + 32'd1 : hold_cnt)
                            : '0;
    end
  end
  assign pwr_pend = (rst_state != drive_ctl_pkg::RST_IDLE);

  // Trip latch; reset clears while held, so a trip during reset is not kept
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      trip_reg <= 1'b0;
    else if (ce_i)
    begin
      if (rst_level)
        trip_reg <= 1'b0; // [R10]
      else if (trip_event_i)
        trip_reg <= 1'b1;
    end
  end
  assign trip_o = trip_reg;

  // Alarm follows trip with one cycle, far inside the 30 ms bound
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      alarm_o <= 1'b0;
    else if (ce_i)
      alarm_o <= trip_reg & ~rst_level; // [R09]
  end

  // Drive off at once while reset held; coasting, no ramp down
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      drive_en_o <= 1'b0;
      pwrrst_reg <= 1'b1;
    end
    else if (ce_i)
    begin
      pwrrst_reg <= rst_level | (rst_state == drive_ctl_pkg::RST_RELEASE);
      drive_en_o <= run_cmd_i & ~trip_reg & ~rst_level & ~pwr_pend; // [R13] [R16]
    end
  end
  assign powerup_reset_o = pwrrst_reg;

  // Logic outputs: immediate off, or held about one second if delayed
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      logic_out_o <= '0;
    else if (ce_i)
      for (int k = 0; k < NOUT; k++)
        if (!rst_level)
          logic_out_o[k] <= logic_out_req_i[k];
        else if (!off_delay_nonzero_i[k])
          logic_out_o[k] <= 1'b0; // [R14]
        else if (hold_cnt >= 32'(HOLD_CYC - 1))
          logic_out_o[k] <= 1'b0; // [R15]
    end

  // ************************************************************
  // Local stop key window
  // ************************************************************
  logic [31:0] pot_cnt;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pot_cnt           <= '0;
      stop_key_accept_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (pot_cnt < 32'(POT_CYC))
        pot_cnt <= pot_cnt + 32'd1;
      stop_key_accept_o <= stop_key_i & (!remote_attached_i | (pot_cnt < 32'(POT_CYC))); // [R17]
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_drive_off_on_reset;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && rst_level) |=> !drive_en_o;
  endproperty
  a_drive_off_on_reset: assert property (p_drive_off_on_reset) else $error("drive on during reset"); // [R13]

  property p_alarm_clear;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && rst_level) |=> !alarm_o;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared"); // [R09]

  property p_trip_clear;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && rst_level) |=> !trip_reg;
  endproperty
  a_trip_clear: assert property (p_trip_clear) else $error("trip not cleared"); // [R10]

  property p_src_disabled;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && frequency_source_param_i != `FREQ_SRC_ANALOG) |=> !analog_freq_en_o;
  endproperty
  a_src_disabled: assert property (p_src_disabled) else $error("analog on when disabled"); // [R03]

  property p_force_v;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && frequency_source_param_i == `FREQ_SRC_ANALOG
       && analog_select_param_i == `ASEL_FORCE_VOLTAGE)
      |=> active_source_o == drive_ctl_pkg::SRC_VOLTAGE;
  endproperty
  a_force_v: assert property (p_force_v) else $error("voltage not forced"); // [R05]

  property p_force_i;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && frequency_source_param_i == `FREQ_SRC_ANALOG
       && analog_select_param_i == `ASEL_FORCE_CURRENT)
      |=> active_source_o == drive_ctl_pkg::SRC_CURRENT;
  endproperty
  a_force_i: assert property (p_force_i) else $error("current not forced"); // [R05]

  property p_powerup_held;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && rst_level) |=> powerup_reset_o;
  endproperty
  a_powerup_held: assert property (p_powerup_held) else $error("power-up reset not held"); // [R10]

  property p_nodelay_off;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && rst_level && off_delay_nonzero_i == '0) |=> logic_out_o == '0;
  endproperty
  a_nodelay_off: assert property (p_nodelay_off) else $error("output not off"); // [R14]

  // Reset held, then the filtered terminal drops
  sequence s_reset_released;
    ce_i && rst_state == drive_ctl_pkg::RST_HELD && !rst_level;
  endsequence

  property p_pwr_state;
    @(posedge clk_i) disable iff (reset_i)
      s_reset_released |=> rst_state == drive_ctl_pkg::RST_RELEASE;
  endproperty
  a_pwr_state: assert property (p_pwr_state) else $error("no reset on release"); // [R07]

  property p_key_window;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && remote_attached_i && pot_cnt >= 32'(POT_CYC)) |=> !stop_key_accept_o;
  endproperty
  a_key_window: assert property (p_key_window) else $error("stop key after window"); // [R17]
endmodule // drive_ctl

// >>> drive_ctl_regs.svh
// Constants for the analog source select and trip reset block
`ifndef DRIVE_CTL_REGS_SVH
`define DRIVE_CTL_REGS_SVH
// Frequency source value that selects the analog terminals
`define FREQ_SRC_ANALOG       8'h01
// Analog select parameter codes
`define ASEL_FORCE_VOLTAGE    8'h04
`define ASEL_FORCE_CURRENT    8'h05
`define ASEL_POT_OR_VOLTAGE   8'h02
`define ASEL_POT_OR_CURRENT   8'h03
`define ASEL_POT_OR_CURRENT_B 8'h09
// Input terminal function codes
`define FUNC_ANALOG_SELECT    8'h10
`define FUNC_TRIP_RESET       8'h12
// Clock rate in kHz and times in ms
`define CLK_KHZ               200000
`define RESET_MIN_MS          12
`define ALARM_CLEAR_MS        30
`define OFF_DELAY_HOLD_MS     1000
`define POT_WINDOW_MS         3000
`define DEBOUNCE_MS           2
// Cycle counts derived from times
`define RESET_MIN_CYC         (`RESET_MIN_MS * `CLK_KHZ)
`define OFF_DELAY_HOLD_CYC    (`OFF_DELAY_HOLD_MS * `CLK_KHZ)
`define POT_WINDOW_CYC        (`POT_WINDOW_MS * `CLK_KHZ)
`define DEBOUNCE_CYC          (`DEBOUNCE_MS * `CLK_KHZ)
`define NUM_TERMINALS         5
`endif

// >>> drive_ctl_pkg.sv
// Types shared by the analog source select and trip reset block
package drive_ctl_pkg;
  typedef enum logic [1:0] {SRC_VOLTAGE, SRC_CURRENT, SRC_POT, SRC_NONE} src_t;
  typedef enum logic [1:0] {RST_IDLE, RST_HELD, RST_RELEASE} rst_state_t;
endpackage

// >>> terminal_if.sv
// Debounced terminal levels passed from the filter to the control core
`timescale 1ns/1ps
interface terminal_if #(parameter int N = 5);
  logic [N-1:0] level;
  modport filter (output level);
  modport core   (input level);
endinterface

// >>> terminal_filter.sv
// Synchroniser and bounce filter for the intelligent input terminals
`timescale 1ns/1ps
`include "drive_ctl_regs.svh"
module terminal_filter #(
  parameter int N       = `NUM_TERMINALS,
  parameter int DEB_CYC = `DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  input  wire logic   ce_i,
  // Raw terminals
  input  wire logic [N-1:0] raw_i,
  // Filtered levels
  terminal_if.filter  out
);
  logic [N-1:0] sync1_reg;
  logic [N-1:0] sync2_reg;
  logic [N-1:0] level_reg;
  logic [31:0]  cnt_reg [N];

  // Two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else if (ce_i)
    begin
      sync1_reg <= raw_i; // [R18]
      sync2_reg <= sync1_reg;
    end
  end

  // Level accepted only after it stays stable for the debounce time
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      level_reg <= '0;
      for (int i = 0; i < N; i++)
        cnt_reg[i] <= '0;
    end
    else if (ce_i)
    begin
      for (int i = 0; i < N; i++)
      begin
        if (sync2_reg[i] == level_reg[i])
          cnt_reg[i] <= '0;
        else if (cnt_reg[i] >= 32'(DEB_CYC - 1))
        begin
          level_reg[i] <= sync2_reg[i]; // [R18]
          cnt_reg[i]   <= '0;
        end
        else
          cnt_reg[i] <= cnt_reg[i] + 32'd1;
      end
    end
  end

  assign out.level = level_reg;
endmodule // terminal_filter

// >>> term_model.sv
// Model of the switches or controller driving the input terminals
`timescale 1ns/1ps
module term_model #(
  parameter int HOLD = 30
) (
  // Clock
  input  wire logic clk_i,
  // Terminal levels, high means closed
  output logic [4:0] term_o
);
  // Contacts start open
  initial term_o = 5'h00;

  // Select level on terminal 0, moved off the sampling edge
  task automatic set_sel(input logic v);
    @(negedge clk_i) term_o[0] = v;
  endtask

  // Reset press on terminal 1; a short press mimics contact bounce
  task automatic press(input logic full);
    int n;
    n = full ? HOLD : 2;
    @(negedge clk_i) term_o[1] = 1'b1;
    repeat (n) @(negedge clk_i);
    term_o[1] = 1'b0;
  endtask
endmodule // term_model

// >>> tb.sv
// Self-checking bench for the analog source select and trip reset block
`timescale 1ns/1ps
`include "drive_ctl_regs.svh"
module tb;
  // Stimulus and observed signals
  logic        clk_i, reset_i, ce_i;
  logic [4:0]  term, inv;
  logic [7:0]  fn [5];
  logic [7:0]  codes [6];
  logic [7:0]  fsrc, asel;
  logic        run, trip_ev, remote, stop, aen, drv, alarm, trip, pur, skacc, s;
  logic [2:0]  lreq, offd, lout;
  logic [1:0]  src;
  logic [15:0] r;
  int          n_errors, n_tests, n, i;

  // ****************************************
  // Design, far side and clock
  // ****************************************
  drive_ctl #(.DEB_CYC(4), .HOLD_CYC(20), .POT_CYC(50), .RMIN_CYC(16)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .terminal_i(term),
    .input_terminal_function_params_i(fn), .terminal_invert_i(inv),
    .frequency_source_param_i(fsrc), .analog_select_param_i(asel),
    .run_cmd_i(run), .trip_event_i(trip_ev), .remote_attached_i(remote),
    .stop_key_i(stop), .logic_out_req_i(lreq), .off_delay_nonzero_i(offd),
    .active_source_o(src), .analog_freq_en_o(aen), .drive_en_o(drv),
    .alarm_o(alarm), .trip_o(trip), .powerup_reset_o(pur), .logic_out_o(lout),
    .stop_key_accept_o(skacc));
  term_model #(.HOLD(30)) model (.clk_i(clk_i), .term_o(term));

  // 200 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Expected source from the configuration and the effective select level
  function automatic logic [1:0] exp_src(input logic [7:0] f, input logic [7:0] a,
                                         input logic e);
    if (f !== `FREQ_SRC_ANALOG) return 2'h3;
    case (a)
      `ASEL_FORCE_VOLTAGE: return 2'h0;
      `ASEL_FORCE_CURRENT: return 2'h1;
      `ASEL_POT_OR_VOLTAGE: return e ? 2'h2 : 2'h0;
      `ASEL_POT_OR_CURRENT, `ASEL_POT_OR_CURRENT_B: return e ? 2'h2 : 2'h1;
      default: return e ? 2'h1 : 2'h0;
    endcase
  endfunction

  function automatic logic sig(input int w);
    return w == 0 ? pur : (w == 1 ? drv : lout[2]);
  endfunction

  // Bounded wait so a stuck output cannot hang the run
  task automatic wait_on(input int w, input logic v);
    n = 0;
    while (sig(w) !== v && n < 60)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask

  // Two sync flops plus the filter span, with margin
  task automatic settle();
    repeat (12) @(negedge clk_i);
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    n_errors = 0;
    n_tests = 0;
    r = 16'h5772;
    codes = '{8'h04, 8'h05, 8'h02, 8'h03, 8'h09, 8'h07};
    fn = '{`FUNC_ANALOG_SELECT, `FUNC_TRIP_RESET, 8'h00, 8'h00, 8'h00};
    reset_i = 1'b1;
    ce_i = 1'b1;
    inv = 5'h00;
    fsrc = `FREQ_SRC_ANALOG;
    asel = 8'h04;
    run = 1'b1;
    trip_ev = 1'b0;
    remote = 1'b1;
    stop = 1'b1;
    lreq = 3'h7;
    offd = 3'h4;
    repeat (4) @(negedge clk_i);
    check(8'(pur), 8'h01);
    check(8'(drv), 8'h00);
    reset_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check(8'(skacc), 8'h01);
    settle();
    check(8'(drv), 8'h01);
    repeat (50) @(negedge clk_i);
    check(8'(skacc), 8'h00);
    // Without the remote the key stays honoured after the window
    remote = 1'b0;
    @(negedge clk_i);
    check(8'(skacc), 8'h01);
    stop = 1'b0;
    @(negedge clk_i);
    check(8'(skacc), 8'h00);
    remote = 1'b1;
    stop = 1'b1;
    // Every select code, random select level, polarity and source
    for (i = 0; i < 24; i++)
    begin
      r = lfsr(r);
      s = r[5];
      asel = codes[i % 6];
      fsrc = (r[4:3] == 2'h0) ? 8'h02 : `FREQ_SRC_ANALOG;
      inv[0] = r[6];
      model.set_sel(s);
      settle();
      check(8'(src), 8'(exp_src(fsrc, asel, s ^ r[6])));
      check(8'(aen), 8'(exp_src(fsrc, asel, s ^ r[6]) != 2'h3));
    end
    // Select function assigned nowhere reads as open
    fn[0] = 8'h00;
    inv = 5'h02;
    fsrc = `FREQ_SRC_ANALOG;
    asel = 8'h07;
    model.set_sel(1'b1);
    settle();
    check(8'(src), 8'h00);
    // Clock enable low freezes the source, enable high lets it follow
    ce_i = 1'b0;
    asel = `ASEL_FORCE_CURRENT;
    settle();
    check(8'(src), 8'h00);
    ce_i = 1'b1;
    settle();
    check(8'(src), 8'h01);
    // Reset while running, random outputs and off delays, bit 2 delayed
    r = lfsr(r);
    lreq = {1'b1, r[1:0]};
    offd = {1'b1, r[3:2]};
    fork
      model.press(1'b1);
    join_none
    wait_on(0, 1'b1);
    check(8'(n < 12), 8'h01);
    check(8'(drv), 8'h00);
    check(8'(lout), 8'(lreq & offd));
    wait_on(2, 1'b0);
    check(8'(n > 17 && n < 23), 8'h01);
    check(8'(lout), 8'h00);
    wait_on(1, 1'b1);
    check(8'(n < 30), 8'h01);
    check(8'(pur), 8'h00);
    // Trip, then a bounce that must not clear it
    @(negedge clk_i) trip_ev = 1'b1;
    @(negedge clk_i) trip_ev = 1'b0;
    @(negedge clk_i);
    check(8'(trip), 8'h01);
    check(8'(alarm), 8'h01);
    model.press(1'b0);
    settle();
    check(8'(trip), 8'h01);
    // Full press clears the trip and the alarm
    fork
      model.press(1'b1);
    join_none
    wait_on(0, 1'b1);
    check(8'(alarm), 8'h00);
    check(8'(trip), 8'h00);
    wait_on(1, 1'b1);
    check(8'(n < 60), 8'h01);
    check(8'(trip), 8'h00);
    // Reset with run off: drive stays off until run returns
    run = 1'b0;
    fork
      model.press(1'b1);
    join_none
    wait_on(0, 1'b1);
    wait_on(0, 1'b0);
    check(8'(n < 60), 8'h01);
    check(8'(drv), 8'h00);
    run = 1'b1;
    repeat (2) @(negedge clk_i);
    check(8'(drv), 8'h01);
    give_verdict();
  end
endmodule // tb
